/* host_io_model.sv */
// host processor model issuing byte i/o cycles to the status block
module host_io_model
	import host_port_pkg::*;
(
	// clock
	input  wire logic       clk_sys,
	// host cycle out, answer back
	output host_cycle_t     hostCycle,
	input  wire logic [7:0] hostRdata,
	input  wire logic       hostRvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial hostCycle = '0;

	// write cycle; released bus shows inverted values
	task automatic ioWrite(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		hostCycle = '{1'b0, 1'b1, a, d};
		@(negedge clk_sys);
		hostCycle = '{1'b0, 1'b0, ~a, ~d};
	endtask

	// read cycle; answer taken half a cycle after the taking edge
	task automatic ioRead(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_sys);
		hostCycle = '{1'b1, 1'b0, a, ~hostCycle.wdata};
		@(negedge clk_sys);
		d = hostRdata;
		v = hostRvalid;
		hostCycle = '{1'b0, 1'b0, ~a, ~hostCycle.wdata};
	endtask
endmodule

/* host_port_pkg.sv */
// package: constants and carriers for the host port status flags
package host_port_pkg;

	// ---------------------------------------------------------------
	// host i/o address decode
	// ---------------------------------------------------------------
	localparam logic [11:0] HOST_ADDR_BASE  = 12'h006;
	localparam logic [3:0]  LOW_OUT_DATA1   = 4'h0;
	localparam logic [3:0]  LOW_STATUS1     = 4'h4;
	localparam logic [3:0]  LOW_STATUS2     = 4'h6;
	localparam int          CHAN_SEL_BIT    = 1;
	localparam int          CMD_ADDR_BIT    = 2;

	// ---------------------------------------------------------------
	// status register layout
	// ---------------------------------------------------------------
	localparam int          STATUS_WIDTH    = 8;
	localparam logic [7:0]  STATUS_RESET    = 8'h00;
	localparam int          BIT_OUT_FULL    = 0;
	localparam int          BIT_IN_FULL     = 1;
	localparam int          BIT_CMD_MARK    = 3;
	localparam logic [7:0]  USER_BITS_MASK  = 8'hF4;
	localparam int          NUM_CHANNELS    = 2;

	// ---------------------------------------------------------------
	// slave processor register selects
	// ---------------------------------------------------------------
	localparam logic [1:0]  SLV_SEL_STATUS  = 2'h0;
	localparam logic [1:0]  SLV_SEL_IN_DATA = 2'h1;
	localparam logic [1:0]  SLV_SEL_OUT_DAT = 2'h2;

	// host i/o cycle as seen by the block
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} host_cycle_t;

	// slave processor register access
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       chan;
		logic [1:0] sel;
		logic [7:0] wdata;
	} slave_access_t;

endpackage

/* host_port_status_flags.sv */
// file: mailbox status flags for two host port channels
// ---------------------------------------------------------------
// status flags and host read decode
// ---------------------------------------------------------------
module host_port_status_flags
	import host_port_pkg::*;
(
	// clock, reset, enable
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic          clkEn,
	// host i/o cycles, already in clk_sys domain
	input  wire host_cycle_t   hostCycle,
	output logic [7:0]         hostRdata,
	output logic               hostRvalid,
	// slave processor access
	input  wire slave_access_t slaveAcc,
	output logic [7:0]         slaveRdata,
	// interrupt requests to slave processor
	output logic [NUM_CHANNELS-1:0] inboundIrq
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] status      [NUM_CHANNELS];
	logic [7:0] inData      [NUM_CHANNELS];
	logic [7:0] outData     [NUM_CHANNELS];
	logic       hostInRange;
	logic       hostWrChan  [NUM_CHANNELS];
	logic       hostOutRd   [NUM_CHANNELS];
	logic       slvInRd     [NUM_CHANNELS];
	logic       slvOutWr    [NUM_CHANNELS];
	logic       slvStatWr   [NUM_CHANNELS];
	logic       hitOut1;
	logic       hitStat1;
	logic       hitStat2;

	// host address decode
	assign hostInRange = (hostCycle.addr[15:4] == HOST_ADDR_BASE) && !hostCycle.addr[3]
		&& !hostCycle.addr[0];
	assign hitOut1  = hostCycle.rd && (hostCycle.addr[15:4] == HOST_ADDR_BASE)
		&& (hostCycle.addr[3:0] == LOW_OUT_DATA1);
	assign hitStat1 = hostCycle.rd && (hostCycle.addr[15:4] == HOST_ADDR_BASE)
		&& (hostCycle.addr[3:0] == LOW_STATUS1);
	assign hitStat2 = hostCycle.rd && (hostCycle.addr[15:4] == HOST_ADDR_BASE)
		&& (hostCycle.addr[3:0] == LOW_STATUS2);

	// ---------------------------------------------------------------
	// per channel flags and data
	// ---------------------------------------------------------------
	for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
		logic chanMatch;
		logic slvHere;
		assign chanMatch    = hostInRange && (hostCycle.addr[CHAN_SEL_BIT] == 1'(c));
		assign hostWrChan[c] = hostCycle.wr && chanMatch;
		assign hostOutRd[c]  = hostCycle.rd && chanMatch && !hostCycle.addr[CMD_ADDR_BIT];
		assign slvHere      = (slaveAcc.chan == 1'(c));
		assign slvInRd[c]   = slaveAcc.rd && slvHere && (slaveAcc.sel == SLV_SEL_IN_DATA);
		assign slvOutWr[c]  = slaveAcc.wr && slvHere && (slaveAcc.sel == SLV_SEL_OUT_DAT);
		assign slvStatWr[c] = slaveAcc.wr && slvHere && (slaveAcc.sel == SLV_SEL_STATUS);

		// host data byte capture
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				inData[c] <= 8'h00;
			end else if (clkEn && hostWrChan[c]) begin
				inData[c] <= hostCycle.wdata;
			end
		end

		// slave output byte
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				outData[c] <= 8'h00;
			end else if (clkEn && slvOutWr[c]) begin
				outData[c] <= slaveAcc.wdata;
			end
		end

		// user bits, writable by slave only
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				status[c][7:4] <= STATUS_RESET[7:4];
				status[c][2]   <= STATUS_RESET[2];
			end else if (clkEn && slvStatWr[c]) begin
				status[c][7:4] <= slaveAcc.wdata[7:4];
				status[c][2]   <= slaveAcc.wdata[2];
			end
		end

		// command marker: address bit two, 1 = command, 0 = data
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				status[c][BIT_CMD_MARK] <= STATUS_RESET[BIT_CMD_MARK];
			end else if (clkEn && hostWrChan[c]) begin
				status[c][BIT_CMD_MARK] <= hostCycle.addr[CMD_ADDR_BIT];
			end
		end

		// inbound full: host write sets, slave read clears, set wins
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				status[c][BIT_IN_FULL] <= STATUS_RESET[BIT_IN_FULL];
			end else if (clkEn) begin
				if (hostWrChan[c]) begin
					status[c][BIT_IN_FULL] <= 1'b1;
				end else if (slvInRd[c]) begin
					status[c][BIT_IN_FULL] <= 1'b0;
				end
			end
		end

		// outbound full: slave write sets, host read or zero write clears
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				status[c][BIT_OUT_FULL] <= STATUS_RESET[BIT_OUT_FULL];
			end else if (clkEn) begin
				if (slvOutWr[c]) begin
					status[c][BIT_OUT_FULL] <= 1'b1;
				end else if (hostOutRd[c]) begin
					status[c][BIT_OUT_FULL] <= 1'b0;
				end else if (slvStatWr[c] && !slaveAcc.wdata[BIT_OUT_FULL]) begin
					status[c][BIT_OUT_FULL] <= 1'b0;
				end
			end
		end

		// interrupt request mirrors inbound full
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				inboundIrq[c] <= 1'b0;
			end else if (clkEn) begin
				inboundIrq[c] <= hostWrChan[c] | (status[c][BIT_IN_FULL] & ~slvInRd[c]);
			end
		end
	end

	// ---------------------------------------------------------------
	// host read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hostRdata  <= 8'h00;
			hostRvalid <= 1'b0;
		end else if (clkEn) begin
			hostRvalid <= hostCycle.rd;
			if (hitStat1) begin
				hostRdata <= status[0];
			end else if (hitStat2) begin
				hostRdata <= status[1];
			end else if (hostOutRd[0] || hostOutRd[1]) begin
				hostRdata <= hostOutRd[0] ? outData[0] : outData[1];
			end else begin
				hostRdata <= 8'h00;
			end
		end
	end

	// ---------------------------------------------------------------
	// slave read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			slaveRdata <= 8'h00;
		end else if (clkEn && slaveAcc.rd) begin
			unique case (slaveAcc.sel)
				SLV_SEL_STATUS:  slaveRdata <= status[slaveAcc.chan];
				SLV_SEL_IN_DATA: slaveRdata <= inData[slaveAcc.chan];
				SLV_SEL_OUT_DAT: slaveRdata <= outData[slaveAcc.chan];
				default:         slaveRdata <= 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_rst_zero;
		@(posedge clk_sys) $rose(rstn) |-> (status[0] == STATUS_RESET && status[1] == STATUS_RESET);
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("status not zero after reset");

	property p_ibf_set;
		@(posedge clk_sys) disable iff (!rstn) clkEn && hostWrChan[0] |=> status[0][BIT_IN_FULL];
	endproperty
	a_ibf_set: assert property (p_ibf_set) else $error("inbound full not set");

	property p_ibf_clr;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && slvInRd[0] && !hostWrChan[0] |=> !status[0][BIT_IN_FULL];
	endproperty
	a_ibf_clr: assert property (p_ibf_clr) else $error("inbound full not cleared");

	property p_obf_set;
		@(posedge clk_sys) disable iff (!rstn) clkEn && slvOutWr[1] |=> status[1][BIT_OUT_FULL];
	endproperty
	a_obf_set: assert property (p_obf_set) else $error("outbound full not set");

	property p_obf_hostclr;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostOutRd[0] && !slvOutWr[0] |=> !status[0][BIT_OUT_FULL];
	endproperty
	a_obf_hostclr: assert property (p_obf_hostclr) else $error("outbound full kept on read");

	property p_obf_one_write;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && slvStatWr[0] && slaveAcc.wdata[0] && !hostOutRd[0] && !slvOutWr[0]
			|=> status[0][BIT_OUT_FULL] == $past(status[0][BIT_OUT_FULL]);
	endproperty
	a_obf_one_write: assert property (p_obf_one_write) else $error("one write moved flag");

	property p_cmd_mark;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostWrChan[1] |=> status[1][BIT_CMD_MARK] == $past(hostCycle.addr[2]);
	endproperty
	a_cmd_mark: assert property (p_cmd_mark) else $error("command marker wrong");

	property p_stat1_read;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hitStat1 |=> hostRdata == $past(status[0]) && hostRvalid;
	endproperty
	a_stat1_read: assert property (p_stat1_read) else $error("status one read wrong");

	property p_stat2_read;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hitStat2 |=> hostRdata == $past(status[1]);
	endproperty
	a_stat2_read: assert property (p_stat2_read) else $error("status two read wrong");

	property p_out1_read;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hitOut1 |=> hostRdata == $past(outData[0]);
	endproperty
	a_out1_read: assert property (p_out1_read) else $error("output one read wrong");

	// ---------------------------------------------------------------
	// further checks on both channels and on flag stability
	// ---------------------------------------------------------------
	property p_ibf_set2;
		@(posedge clk_sys) disable iff (!rstn) clkEn && hostWrChan[1] |=> status[1][BIT_IN_FULL];
	endproperty
	a_ibf_set2: assert property (p_ibf_set2) else $error("inbound full two not set");

	property p_ibf_clr2;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && slvInRd[1] && !hostWrChan[1] |=> !status[1][BIT_IN_FULL];
	endproperty
	a_ibf_clr2: assert property (p_ibf_clr2) else $error("inbound full two kept");

	property p_obf_set1;
		@(posedge clk_sys) disable iff (!rstn) clkEn && slvOutWr[0] |=> status[0][BIT_OUT_FULL];
	endproperty
	a_obf_set1: assert property (p_obf_set1) else $error("outbound full one not set");

	property p_obf_zero_clr;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && slvStatWr[0] && !slaveAcc.wdata[0] && !slvOutWr[0] |=> !status[0][BIT_OUT_FULL];
	endproperty
	a_obf_zero_clr: assert property (p_obf_zero_clr) else $error("zero write kept flag");

	property p_obf_hostclr2;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostOutRd[1] && !slvOutWr[1] |=> !status[1][BIT_OUT_FULL];
	endproperty
	a_obf_hostclr2: assert property (p_obf_hostclr2) else $error("outbound two kept");

	property p_obf_set_wins;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && slvOutWr[0] && hostOutRd[0] |=> status[0][BIT_OUT_FULL];
	endproperty
	a_obf_set_wins: assert property (p_obf_set_wins) else $error("clear beat set");

	property p_irq_follow;
		@(posedge clk_sys) disable iff (!rstn)
			inboundIrq == {status[1][BIT_IN_FULL], status[0][BIT_IN_FULL]};
	endproperty
	a_irq_follow: assert property (p_irq_follow) else $error("irq differs from flag");

	property p_cmd_mark1;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostWrChan[0] |=> status[0][BIT_CMD_MARK] == $past(hostCycle.addr[CMD_ADDR_BIT]);
	endproperty
	a_cmd_mark1: assert property (p_cmd_mark1) else $error("command marker one wrong");

	property p_cmd_ro;
		@(posedge clk_sys) disable iff (!rstn)
			!(clkEn && hostWrChan[0]) |=> $stable(status[0][BIT_CMD_MARK]);
	endproperty
	a_cmd_ro: assert property (p_cmd_ro) else $error("command marker moved");

	property p_ibf_ro;
		@(posedge clk_sys) disable iff (!rstn)
			!(clkEn && (hostWrChan[0] || slvInRd[0])) |=> $stable(status[0][BIT_IN_FULL]);
	endproperty
	a_ibf_ro: assert property (p_ibf_ro) else $error("inbound full moved");

	property p_user_wr;
		@(posedge clk_sys) disable iff (!rstn) clkEn && slvStatWr[1]
			|=> (status[1] & USER_BITS_MASK) == ($past(slaveAcc.wdata) & USER_BITS_MASK);
	endproperty
	a_user_wr: assert property (p_user_wr) else $error("user bits not written");

	property p_user_hold;
		@(posedge clk_sys) disable iff (!rstn)
			!(clkEn && slvStatWr[0]) |=> $stable(status[0] & USER_BITS_MASK);
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("user bits moved");

	property p_in_data;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostWrChan[0] |=> inData[0] == $past(hostCycle.wdata);
	endproperty
	a_in_data: assert property (p_in_data) else $error("host byte not stored");

	property p_out2_read;
		@(posedge clk_sys) disable iff (!rstn)
			clkEn && hostOutRd[1] |=> hostRdata == $past(outData[1]);
	endproperty
	a_out2_read: assert property (p_out2_read) else $error("output two read wrong");

	property p_rvalid;
		@(posedge clk_sys) disable iff (!rstn) clkEn && hostCycle.rd |=> hostRvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read valid missing");

endmodule

/* tb.sv */
// self-checking bench for the host port status flags
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin \
	$display("mismatch %s exp %h got %h", n, e, g); nErrors++; end end
module tb
	import host_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk_sys = 1'b0;
	logic          rstn = 1'b0;
	host_cycle_t   hostCycle;
	slave_access_t slaveAcc = '0;
	logic [7:0]    hostRdata, slaveRdata, rd;
	logic [7:0]    st[2] = '{8'h00, 8'h00};
	logic [7:0]    host_to_slave_byte[2] = '{8'h00, 8'h00};
	logic [7:0]    slave_to_host_byte[2] = '{8'h00, 8'h00};
	logic [1:0]    inboundIrq;
	logic          hostRvalid, v;
	logic [31:0]   r;
	int            seed = 32'h78452e6e;
	int            nErrors = 0;
	int            checkCount = 0;
	int            c;

	host_port_status_flags i_dut (.clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1),
		.hostCycle(hostCycle), .hostRdata(hostRdata), .hostRvalid(hostRvalid),
		.slaveAcc(slaveAcc), .slaveRdata(slaveRdata), .inboundIrq(inboundIrq));
	host_io_model i_host (.clk_sys(clk_sys), .hostCycle(hostCycle),
		.hostRdata(hostRdata), .hostRvalid(hostRvalid));

	// clock
	initial forever #2.5 clk_sys = ~clk_sys;

	// host address of a channel byte, status when sel is set
	function automatic logic [15:0] hAddr(input int ch, input logic sel);
		return {HOST_ADDR_BASE, 1'b0, sel, ch[0], 1'b0};
	endfunction

	// status after a slave status write
	function automatic logic [7:0] stWr(input logic [7:0] s, input logic [7:0] d);
		return (s & 8'h0B & {7'h7F, d[0]}) | (d & USER_BITS_MASK);
	endfunction

	// one slave access pulse
	task automatic slv(input logic rdS, input logic wrS, input int ch,
		input logic [1:0] sel, input logic [7:0] d);
		@(negedge clk_sys);
		slaveAcc = '{rdS, wrS, ch[0], sel, d};
		@(negedge clk_sys);
		slaveAcc = '0;
	endtask

	// host read and compare
	task automatic hRd(input logic [15:0] a, input logic [7:0] e);
		i_host.ioRead(a, rd, v);
		`CHK("hostRvalid", 1'b1, v)
		`CHK("hostRdata", e, rd)
	endtask

	// verdict and end of run
	task automatic stopTest();
		if (nErrors == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog
	initial begin
		#(5ns * 20000);
		nErrors++;
		stopTest();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys) rstn = 1'b1;
		hRd(hAddr(0, 1'b1), 8'h00);
		hRd(hAddr(1, 1'b1), 8'h00);
		// set and clear of both flags in one cycle
		fork
			i_host.ioWrite(hAddr(0, 1'b1), 8'h5A);
			slv(1'b1, 1'b0, 0, SLV_SEL_IN_DATA, 8'h00);
		join
		`CHK("slaveRdata", 8'h00, slaveRdata)
		st[0] = 8'h0A;
		host_to_slave_byte[0] = 8'h5A;
		fork
			hRd(hAddr(0, 1'b0), 8'h00);
			slv(1'b0, 1'b1, 0, SLV_SEL_OUT_DAT, 8'hC3);
		join
		st[0][0] = 1'b1;
		slave_to_host_byte[0] = 8'hC3;
		hRd(hAddr(0, 1'b1), st[0]);
		// random traffic against the reference
		repeat (400) begin
			r = $random(seed);
			c = r[9];
			case (r[12:10])
				3'h0: begin
					i_host.ioWrite(hAddr(c, r[8]), r[7:0]);
					st[c][3] = r[8];
					st[c][1] = 1'b1;
					host_to_slave_byte[c] = r[7:0];
				end
				3'h1: hRd(hAddr(c, 1'b1), st[c]);
				3'h2: begin
					hRd(hAddr(c, 1'b0), slave_to_host_byte[c]);
					st[c][0] = 1'b0;
				end
				3'h3: begin
					slv(1'b1, 1'b0, c, SLV_SEL_IN_DATA, r[7:0]);
					`CHK("slaveRdata", host_to_slave_byte[c], slaveRdata)
					st[c][1] = 1'b0;
				end
				3'h4: begin
					slv(1'b1, 1'b0, c, SLV_SEL_STATUS, r[7:0]);
					`CHK("slaveRdata", st[c], slaveRdata)
				end
				3'h5: begin
					slv(1'b0, 1'b1, c, SLV_SEL_STATUS, r[7:0]);
					st[c] = stWr(st[c], r[7:0]);
				end
				3'h6: begin
					slv(1'b0, 1'b1, c, SLV_SEL_OUT_DAT, r[7:0]);
					slave_to_host_byte[c] = r[7:0];
					st[c][0] = 1'b1;
					slv(1'b1, 1'b0, c, SLV_SEL_OUT_DAT, r[7:0]);
					`CHK("slaveRdata", slave_to_host_byte[c], slaveRdata)
				end
				default: begin
					i_host.ioWrite({4'hB, r[11:0]}, r[7:0]);
					hRd({4'hA, r[11:0]}, 8'h00);
				end
			endcase
			`CHK("inboundIrq", {st[1][1], st[0][1]}, inboundIrq)
		end
		stopTest();
	end
endmodule
